/* File: src/lbcc_pkg.sv */
package lbcc_pkg;

    // ************************************************************
    // Register map (word index; byte address is four times it)
    // ************************************************************
    localparam int         WB_ADR_W     = 10;
    localparam int         REG_IDX_LSB  = 2;
    localparam logic [7:0] FEAT3_IDX    = 8'had;
    localparam logic [7:0] CACHE2_IDX   = 8'hd1;
    localparam logic [7:0] STATUS_IDX   = 8'hf0;
    localparam logic [7:0] FEAT3_RST    = 8'h00;
    localparam logic [7:0] CACHE2_RST   = 8'h41;
    localparam int         ADS_LATCH_BIT = 6;
    localparam int         RDY_DIRECT_BIT = 0;
    localparam int         RECLAIM_BIT  = 7;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic                cyc;
        logic                stb;
        logic                we;
        logic [WB_ADR_W-1:0] adr;
        logic [3:0]          sel;
        logic [31:0]         dat;
    } wb_req_s;

    typedef struct packed {
        logic mem_io;
        logic wr_rd;
        logic data_code;
    } cyc_type_s;

    typedef struct packed {
        logic ior_n;
        logic iow_n;
        logic memr_n;
        logic memw_n;
    } isa_strb_s;

    typedef enum logic [2:0] {
        CY_IDLE  = 3'b000,
        CY_LATCH = 3'b001,
        CY_T2    = 3'b010,
        CY_LOCAL = 3'b011,
        CY_ISA   = 3'b100,
        CY_DRAM  = 3'b101
    } cyc_state_e;

    typedef enum logic [2:0] {
        ARB_IDLE = 3'b000,
        ARB_HOLD = 3'b001,
        ARB_RFSH = 3'b010,
        ARB_DMA  = 3'b011,
        ARB_LBM  = 3'b100
    } arb_state_e;

endpackage

/* File: src/cfg_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module cfg_regs
    import lbcc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire wb_req_s    wb_req,
    input  wire logic [7:0] status,
    output logic [31:0]     wb_dat_o,
    output logic            wb_ack_o,
    output logic [7:0]      feat3,
    output logic [7:0]      cache2
);

    logic [7:0] idx;
    logic       req;
    assign idx = wb_req.adr[WB_ADR_W-1:REG_IDX_LSB];
    assign req = wb_req.cyc & wb_req.stb;

    // Ack drops the cycle after it is given, so back to back needs a gap
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req & ~wb_ack_o) begin
            unique case (idx)
                FEAT3_IDX:  wb_dat_o <= {24'h000000, feat3};
                CACHE2_IDX: wb_dat_o <= {24'h000000, cache2};
                STATUS_IDX: wb_dat_o <= {24'h000000, status};
                default:    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Write lands on the edge where the master sees ack
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            feat3  <= FEAT3_RST;
            cache2 <= CACHE2_RST;
        end else if (req & wb_ack_o & wb_req.we & wb_req.sel[0]) begin
            if (idx == FEAT3_IDX) begin
                feat3 <= wb_req.dat[7:0];
            end
            if (idx == CACHE2_IDX) begin
                cache2 <= wb_req.dat[7:0];
            end
        end
    end

endmodule // cfg_regs
`default_nettype wire

/* File: src/hold_arbiter.sv */
`timescale 1ns/1ns
`default_nettype none
module hold_arbiter
    import lbcc_pkg::*;
#(
    parameter int N_DMA = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             rfsh_req,
    input  wire logic             rfsh_done,
    input  wire logic [N_DMA-1:0] drq,
    input  wire logic             dma_to_mem,
    input  wire logic             lreq_n,
    input  wire logic             hlda,
    output logic                  hold,
    output logic [N_DMA-1:0]      dack_n,
    output isa_strb_s             strb,
    output logic                  lgnt_n,
    output logic                  rfsh_run,
    output arb_state_e            state
);

    if (N_DMA < 1 || N_DMA > 8) begin : g_chk
        $error("hold_arbiter: N_DMA must be 1..8");
    end

    function automatic logic [N_DMA-1:0] lowest(input logic [N_DMA-1:0] v);
        logic [N_DMA-1:0] r;
        r = v & (~v + N_DMA'(1));
        return r;
    endfunction

    arb_state_e       target;
    arb_state_e       next_state;
    logic [N_DMA-1:0] chan;
    logic             pend;
    logic             rfsh_due;
    logic             rfsh_taken;

    // A request on the owner's last cycle goes straight to refresh, not through idle
    assign rfsh_due   = pend | rfsh_req;
    assign rfsh_taken = (next_state == ARB_RFSH) & ((state == ARB_DMA) | (state == ARB_LBM));

    // Refresh stays latched while another owner holds the bus; set wins
    // unless that same request is being served at this edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend <= 1'b0;
        end else if (rfsh_req & ~rfsh_taken) begin
            pend <= 1'b1;
        end else if (next_state == ARB_RFSH) begin
            pend <= 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ARB_IDLE: if (pend | rfsh_req | (|drq) | ~lreq_n) next_state = ARB_HOLD;
            ARB_HOLD: if (hlda) next_state = target;
            ARB_RFSH: if (rfsh_done) next_state = ARB_IDLE;
            ARB_DMA:  if (~|(drq & chan)) next_state = rfsh_due ? ARB_RFSH : ARB_IDLE;
            ARB_LBM:  if (lreq_n) next_state = rfsh_due ? ARB_RFSH : ARB_IDLE;
            default:  next_state = ARB_IDLE;
        endcase
    end

    // First come first served: the choice is fixed when hold is raised
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state  <= ARB_IDLE;
            target <= ARB_IDLE;
            chan   <= '0;
        end else begin
            state <= next_state;
            if (state == ARB_IDLE) begin
                if (pend | rfsh_req) begin
                    target <= ARB_RFSH;
                end else if (|drq) begin
                    target <= ARB_DMA;
                    chan   <= lowest(drq);
                end else begin
                    target <= ARB_LBM;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hold     <= 1'b0;
            dack_n   <= '1;
            strb     <= '1;
            lgnt_n   <= 1'b1;
            rfsh_run <= 1'b0;
        end else begin
            hold     <= next_state != ARB_IDLE;
            rfsh_run <= next_state == ARB_RFSH;
            lgnt_n   <= next_state != ARB_LBM;
            dack_n   <= (next_state == ARB_DMA) ? ~chan : '1;
            strb.ior_n  <= ~((next_state == ARB_DMA) & dma_to_mem);
            strb.memw_n <= ~((next_state == ARB_DMA) & dma_to_mem);
            strb.iow_n  <= ~((next_state == ARB_DMA) & ~dma_to_mem);
            strb.memr_n <= ~((next_state == ARB_DMA) & ~dma_to_mem);
        end
    end

endmodule // hold_arbiter
`default_nettype wire

/* File: src/local_bus_cycle_control.sv */
`timescale 1ns/1ns
`default_nettype none
module local_bus_cycle_control
    import lbcc_pkg::*;
#(
    parameter int N_DMA = 4
) (
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // Wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [WB_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o,
    // Processor cycle side
    input  wire logic                ads_n,
    input  wire cyc_type_s           cyc_type_in,
    input  wire logic                in_dram_range,
    input  wire logic                ldev_n,
    input  wire logic                local_ready_input_n,
    input  wire logic                blast_n,
    input  wire logic                dram_xfer_done,
    input  wire logic                isa_done,
    output logic                     rdy_n,
    output logic                     brdy_n,
    output logic                     isa_start,
    output logic                     dram_start,
    output cyc_type_s                cycle_type,
    // Bus ownership side
    input  wire logic                rfsh_req,
    input  wire logic                rfsh_done,
    input  wire logic [N_DMA-1:0]    drq,
    input  wire logic                dma_to_mem,
    input  wire logic                lreq_n,
    input  wire logic                hlda,
    output logic                     hold,
    output logic [N_DMA-1:0]         dack_n,
    output isa_strb_s                isa_strb,
    output logic                     lgnt_n,
    output logic                     rfsh_run
);

    // ************************************************************
    // Configuration registers
    // ************************************************************
    wb_req_s    wb_req;
    logic [7:0] feat3;
    logic [7:0] cache2;
    logic [7:0] status;
    arb_state_e arb_state;
    cyc_state_e state;

    assign wb_req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                      adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
    assign status = {1'b0, arb_state, 1'b0, state};

    cfg_regs u_regs (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .wb_req   (wb_req),
        .status   (status),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .feat3    (feat3),
        .cache2   (cache2)
    );

    logic latch_mode;
    logic ready_direct;
    logic reclaim_en;
    assign latch_mode   = cache2[ADS_LATCH_BIT];
    assign ready_direct = feat3[RDY_DIRECT_BIT];
    assign reclaim_en   = feat3[RECLAIM_BIT];

    // ************************************************************
    // Cycle sequencing
    // ************************************************************
    logic local_ready;
    logic claim_lost;
    logic to_isa;
    logic ready_latched;
    assign local_ready = (state == CY_LOCAL) & ~local_ready_input_n;
    // Without the reclaim bit a vanished claim hangs the bus by design
    assign claim_lost  = (state == CY_LOCAL) & local_ready_input_n
                         & ldev_n & reclaim_en;
    assign to_isa      = ((state == CY_T2) & ~in_dram_range & ldev_n) | claim_lost;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= CY_IDLE;
        end else begin
            unique case (state)
                CY_IDLE: begin
                    if (!ads_n) begin
                        state <= latch_mode ? CY_LATCH : CY_T2;
                    end
                end
                CY_LATCH: state <= CY_T2;
                CY_T2: begin
                    if (in_dram_range) begin
                        state <= CY_DRAM;
                    end else if (!ldev_n) begin
                        state <= CY_LOCAL;
                    end else begin
                        state <= CY_ISA;
                    end
                end
                CY_LOCAL: begin
                    if (local_ready) begin
                        state <= CY_IDLE;
                    end else if (claim_lost) begin
                        state <= CY_ISA;
                    end
                end
                CY_ISA: begin
                    if (isa_done) begin
                        state <= CY_IDLE;
                    end
                end
                CY_DRAM: begin
                    if (dram_xfer_done && !blast_n) begin
                        state <= CY_IDLE;
                    end
                end
                default: state <= CY_IDLE;
            endcase
        end
    end

    // Early capture saves a clock but relies on tight ADS timing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cycle_type <= '0;
        end else if ((state == CY_IDLE) && !ads_n && !latch_mode) begin
            cycle_type <= cyc_type_in;
        end else if (state == CY_LATCH) begin
            cycle_type <= cyc_type_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            isa_start  <= 1'b0;
            dram_start <= 1'b0;
        end else begin
            isa_start  <= to_isa;
            dram_start <= (state == CY_T2) & in_dram_range;
        end
    end

    // ************************************************************
    // Ready paths
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ready_latched <= 1'b0;
        end else begin
            ready_latched <= local_ready & ~ready_direct;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdy_n <= 1'b1;
        end else begin
            rdy_n <= ~((local_ready & ready_direct) | ready_latched
                       | ((state == CY_ISA) & isa_done));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            brdy_n <= 1'b1;
        end else begin
            brdy_n <= ~((state == CY_DRAM) & dram_xfer_done);
        end
    end

    // ************************************************************
    // Bus ownership
    // ************************************************************
    hold_arbiter #(
        .N_DMA (N_DMA)
    ) u_arb (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .rfsh_req   (rfsh_req),
        .rfsh_done  (rfsh_done),
        .drq        (drq),
        .dma_to_mem (dma_to_mem),
        .lreq_n     (lreq_n),
        .hlda       (hlda),
        .hold       (hold),
        .dack_n     (dack_n),
        .strb       (isa_strb),
        .lgnt_n     (lgnt_n),
        .rfsh_run   (rfsh_run),
        .state      (arb_state)
    );

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_EARLY_DECODE: assert property (@(posedge sys_clk) disable iff (rst)
        (state == CY_IDLE) && !ads_n && !latch_mode
        |=> (state == CY_T2) && (cycle_type == $past(cyc_type_in)))
        else $error("early decode missed");

    AST_LATCH_DECODE: assert property (@(posedge sys_clk) disable iff (rst)
        (state == CY_IDLE) && !ads_n && latch_mode
        |=> (state == CY_LATCH) ##1 (state == CY_T2))
        else $error("latched decode sequence wrong");

    AST_RESET_LATCH: assert property (@(posedge sys_clk)
        $fell(rst) |-> latch_mode && (state == CY_IDLE))
        else $error("latched sampling not default");

    AST_CLAIM: assert property (@(posedge sys_clk) disable iff (rst)
        (state == CY_T2) && !in_dram_range && !ldev_n
        |=> (state == CY_LOCAL) && !isa_start)
        else $error("claim not honoured");

    AST_TO_ISA: assert property (@(posedge sys_clk) disable iff (rst)
        (state == CY_T2) && !in_dram_range && ldev_n
        |=> (state == CY_ISA) && isa_start ##1 !isa_start)
        else $error("unclaimed cycle not forwarded");

    AST_DRAM_IGNORE: assert property (@(posedge sys_clk) disable iff (rst)
        (state == CY_T2) && in_dram_range |=> (state == CY_DRAM) && dram_start)
        else $error("claim not ignored in DRAM range");

    AST_WAIT: assert property (@(posedge sys_clk) disable iff (rst)
        (state == CY_LOCAL) && !reclaim_en && local_ready_input_n
        |=> (state == CY_LOCAL) && rdy_n)
        else $error("claimed cycle left without ready");

    AST_RECLAIM: assert property (@(posedge sys_clk) disable iff (rst)
        (state == CY_LOCAL) && reclaim_en && ldev_n && local_ready_input_n
        |=> (state == CY_ISA) && isa_start)
        else $error("dropped claim not reclaimed");

    AST_NO_TIMEOUT: assert property (@(posedge sys_clk) disable iff (rst)
        (state == CY_LOCAL) && !ldev_n && local_ready_input_n
        |=> state == CY_LOCAL)
        else $error("claim left while still asserted");

    AST_RDY_DIRECT: assert property (@(posedge sys_clk) disable iff (rst)
        local_ready && ready_direct |=> !rdy_n ##1 rdy_n)
        else $error("direct ready not same clock");

    AST_RDY_SYNC: assert property (@(posedge sys_clk) disable iff (rst)
        local_ready && !ready_direct |=> rdy_n ##1 !rdy_n)
        else $error("latched ready not next clock");

    AST_ISA_RDY: assert property (@(posedge sys_clk) disable iff (rst)
        (state == CY_ISA) && isa_done |=> !rdy_n ##1 rdy_n)
        else $error("ISA end ready missing");

    AST_GRANT_AFTER_HLDA: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(lgnt_n) || $rose(rfsh_run) || ($past(&dack_n) && !(&dack_n))
        |-> $past(hlda) && hold)
        else $error("grant before HLDA");

    // ************************************************************
    // Ownership and burst checks
    // ************************************************************

    AST_HOLD_NO_GRANT: assert property (@(posedge sys_clk) disable iff (rst)
        (arb_state == ARB_HOLD) |-> hold && (&dack_n) && lgnt_n && !rfsh_run)
        else $error("grant while waiting for HLDA");

    AST_RFSH_OWNS: assert property (@(posedge sys_clk) disable iff (rst)
        (arb_state == ARB_RFSH) |-> rfsh_run && hold && (&dack_n) && lgnt_n)
        else $error("refresh owner outputs wrong");

    AST_DMA_STROBES: assert property (@(posedge sys_clk) disable iff (rst)
        (arb_state == ARB_DMA) |-> $onehot(~dack_n)
        && (isa_strb.ior_n == !$past(dma_to_mem)) && (isa_strb.memw_n == isa_strb.ior_n)
        && (isa_strb.iow_n == $past(dma_to_mem)) && (isa_strb.memr_n == isa_strb.iow_n))
        else $error("DMA acknowledge or strobe pair wrong");

    AST_LBM_GRANT: assert property (@(posedge sys_clk) disable iff (rst)
        (arb_state == ARB_LBM) |-> !lgnt_n && hold && (&dack_n) && !rfsh_run)
        else $error("local master grant wrong");

    AST_RFSH_QUEUED: assert property (@(posedge sys_clk) disable iff (rst)
        ((arb_state == ARB_DMA) || (arb_state == ARB_LBM)) && rfsh_req
        |=> hold && (arb_state != ARB_IDLE) && (arb_state != ARB_HOLD))
        else $error("refresh behind an owner not kept");

    AST_RDY_ONE: assert property (@(posedge sys_clk) disable iff (rst)
        !rdy_n |=> rdy_n)
        else $error("CPU ready longer than one clock");

    AST_BURST_NEXT: assert property (@(posedge sys_clk) disable iff (rst)
        (state == CY_DRAM) && dram_xfer_done && blast_n |=> !brdy_n && (state == CY_DRAM))
        else $error("burst transfer ready missing");

    AST_BURST_LAST: assert property (@(posedge sys_clk) disable iff (rst)
        (state == CY_DRAM) && dram_xfer_done && !blast_n |=> !brdy_n && (state == CY_IDLE))
        else $error("last burst transfer not ended");

    COV_LBM: cover property (@(posedge sys_clk) disable iff (rst)
        (arb_state == ARB_LBM));
    COV_LOCAL: cover property (@(posedge sys_clk) disable iff (rst)
        (state == CY_LOCAL) ##[1:20] !rdy_n);
    COV_RECLAIM: cover property (@(posedge sys_clk) disable iff (rst)
        claim_lost);
    COV_ISA: cover property (@(posedge sys_clk) disable iff (rst)
        (state == CY_ISA) && isa_done);
    COV_RFSH_AFTER_DMA: cover property (@(posedge sys_clk) disable iff (rst)
        (arb_state == ARB_DMA) ##1 (arb_state == ARB_RFSH));

endmodule // local_bus_cycle_control
`default_nettype wire

/* File: dv/cpu_hold_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ************
// CPU end of hold
// ************
module cpu_hold_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       hold,
    input  wire logic [3:0] lag,
    output logic            hlda
);
    logic [3:0] wait_cnt;

    // Lag stands for the bus cycle the CPU must finish before letting go
    always_ff @(posedge sys_clk) begin
        if (rst || !hold) begin
            wait_cnt <= 4'h0;
            hlda     <= 1'h0;
        end else if (wait_cnt < lag) begin
            wait_cnt <= wait_cnt + 4'h1;
        end else begin
            hlda <= 1'h1;
        end
    end
endmodule // cpu_hold_model
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import lbcc_pkg::*;
;
    // ************
    // Bench signals
    // ************
    logic                sys_clk = 1'h0;
    logic                rst = 1'h1;
    logic                wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [WB_ADR_W-1:0] wb_adr_i = 10'h000;
    logic [31:0]         wb_dat_i = 32'h0;
    logic                ads_n = 1'h1, in_dram_range = 1'h0, ldev_n = 1'h1;
    logic                local_ready_input_n = 1'h1, blast_n = 1'h1;
    logic                dram_xfer_done = 1'h0, isa_done = 1'h0, rfsh_req = 1'h0;
    logic                rfsh_done = 1'h0, dma_to_mem = 1'h0, lreq_n = 1'h1;
    logic [3:0]          drq = 4'h0, lag = 4'h5;
    cyc_type_s           cyc_type_in = 3'h0;
    logic [31:0]         wb_dat_o;
    logic                wb_ack_o, rdy_n, brdy_n, isa_start, dram_start, hold;
    logic                lgnt_n, rfsh_run, hlda;
    logic [3:0]          dack_n;
    cyc_type_s           cycle_type;
    isa_strb_s           isa_strb;
    int                  miscompares = 0;
    int                  tests_run = 0;
    int                  n;
    logic [7:0]          q;
    wire logic [9:0]     obs = {wb_ack_o, dack_n[2], rfsh_run, lgnt_n, dack_n[1], hold,
                                brdy_n, dram_start, isa_start, rdy_n};

    always #5 sys_clk = ~sys_clk;

    local_bus_cycle_control #(.N_DMA(4)) i_local_bus_cycle_control (
        .sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'h1),
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .ads_n, .cyc_type_in, .in_dram_range, .ldev_n,
        .local_ready_input_n, .blast_n, .dram_xfer_done, .isa_done, .rdy_n, .brdy_n,
        .isa_start, .dram_start, .cycle_type, .rfsh_req, .rfsh_done, .drq, .dma_to_mem,
        .lreq_n, .hlda, .hold, .dack_n, .isa_strb, .lgnt_n, .rfsh_run
    );
    cpu_hold_model i_cpu_hold_model (.sys_clk, .rst, .hold, .lag, .hlda);

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Edges until observed bit k reads v; running out of edges ends the run
    task automatic wait_for(input int k, input logic v, output int cnt);
        cnt = 0;
        do begin
            @(posedge sys_clk);
            cnt++;
        end while (obs[k] !== v && cnt < 60);
        if (cnt >= 60) begin
            miscompares++;
            give_verdict();
        end
    endtask

    task automatic stays(input int k, input logic v, input int c);
        repeat (c) begin
            @(posedge sys_clk);
            chk("steady", v, obs[k]);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [7:0] rd);
        int cnt;
        @(posedge sys_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= w;
        wb_adr_i <= {idx, 2'h0};
        wb_dat_i <= {24'h0, d};
        wait_for(9, 1'h1, cnt);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask

    // Address strobe low for one clock; type stays put throughout
    task automatic cpu_cycle();
        @(posedge sys_clk);
        ads_n <= 1'h0;
        @(posedge sys_clk);
        ads_n <= 1'h1;
    endtask

    task automatic isa_end();
        isa_done <= 1'h1;
        @(posedge sys_clk);
        isa_done <= 1'h0;
        wait_for(0, 1'h0, n);
        chk("isa ready", 1, n);
        @(posedge sys_clk);
        chk("ready width", 1'h1, rdy_n);
    endtask

    task automatic pulse(input int k, input logic b);
        blast_n <= b;
        dram_xfer_done <= (k == 3);
        local_ready_input_n <= (k != 0);
        @(posedge sys_clk);
        dram_xfer_done <= 1'h0;
        local_ready_input_n <= 1'h1;
        blast_n <= 1'h1;
        wait_for(k, 1'h0, n);
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'h0;
        wb(1'h0, CACHE2_IDX, 8'h00, q);
        chk("cache2 reset", 8'h41, q);
        wb(1'h0, FEAT3_IDX, 8'h00, q);
        chk("feat3 reset", FEAT3_RST, q);
        wb(1'h1, 8'h10, 8'hff, q);
        wb(1'h0, 8'h10, 8'h00, q);
        chk("unmapped", 8'h00, q);
        $display("test registers done");
        for (int m = 0; m < 2; m++) begin
            cyc_type_in <= m ? 3'h2 : 3'h5;
            cpu_cycle();
            wait_for(1, 1'h1, n);
            chk("isa start", 3 - m, n);
            chk("type", m ? 3'h2 : 3'h5, cycle_type);
            isa_end();
            wb(1'h1, CACHE2_IDX, 8'h01, q);
        end
        $display("test sampling done");
        for (int b = 0; b < 2; b++) begin
            wb(1'h1, FEAT3_IDX, {7'h0, b[0]}, q);
            ldev_n <= 1'h0;
            cpu_cycle();
            repeat (3) @(posedge sys_clk);
            ldev_n <= 1'h1;
            stays(1, 1'h0, 6);
            pulse(0, 1'h1);
            chk("local ready", 2 - b, n);
        end
        wb(1'h1, FEAT3_IDX, 8'h81, q);
        ldev_n <= 1'h0;
        cpu_cycle();
        stays(1, 1'h0, 30);
        ldev_n <= 1'h1;
        wait_for(1, 1'h1, n);
        chk("reclaim", 2, n);
        isa_end();
        $display("test claim done");
        in_dram_range <= 1'h1;
        ldev_n <= 1'h0;
        cpu_cycle();
        wait_for(2, 1'h1, n);
        chk("dram start", 2, n);
        pulse(3, 1'h1);
        chk("burst ready", 1, n);
        pulse(3, 1'h0);
        chk("last ready", 1, n);
        in_dram_range <= 1'h0;
        ldev_n <= 1'h1;
        cpu_cycle();
        wait_for(1, 1'h1, n);
        chk("idle after burst", 2, n);
        isa_end();
        $display("test dram done");
        dma_to_mem <= 1'h1;
        drq <= 4'h2;
        wait_for(4, 1'h1, n);
        chk("no early grant", 4'hf, dack_n);
        wait_for(5, 1'h0, n);
        chk("hlda first", 1'h1, hlda);
        chk("dma strobes", 4'h6, isa_strb);
        rfsh_req <= 1'h1;
        @(posedge sys_clk);
        rfsh_req <= 1'h0;
        stays(7, 1'h0, 3);
        drq <= 4'h0;
        wait_for(7, 1'h1, n);
        chk("hold kept", 1'h1, hold);
        rfsh_done <= 1'h1;
        @(posedge sys_clk);
        rfsh_done <= 1'h0;
        wait_for(4, 1'h0, n);
        lag <= 4'h1;
        dma_to_mem <= 1'h0;
        drq <= 4'h4;
        wait_for(4, 1'h1, n);
        lreq_n <= 1'h0;
        wait_for(8, 1'h0, n);
        chk("first come", 1'h1, lgnt_n);
        chk("dma strobes", 4'h9, isa_strb);
        drq <= 4'h0;
        wait_for(6, 1'h0, n);
        chk("grant after hlda", 1'h1, hlda);
        lreq_n <= 1'h1;
        wait_for(4, 1'h0, n);
        $display("test ownership done");
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
